// ===== frame_codec_pkg.sv
// Shared constants, types and helpers for the link frame codec ends
package frame_codec_pkg;
	// ==================================================================
	// Frame format
	localparam logic [7:0]  FLAG_OCTET = 8'h7E;
	localparam logic [6:0]  MARK_FOUR  = 7'h7E;
	localparam logic [6:0]  MARK_SIX   = 7'h7D;
	localparam logic [2:0]  LEN_FOUR   = 3'h4;
	localparam logic [2:0]  LEN_SIX    = 3'h6;
	localparam logic [4:0]  MAX_DEST   = 5'h10;
	localparam logic [4:0]  MAX_INFO   = 5'h10;
	localparam logic [2:0]  STUFF_RUN  = 3'h5;
	localparam logic [2:0]  FLAG_RUN   = 3'h6;
	localparam logic [15:0] FCS_INIT   = 16'hFFFF;
	localparam logic [15:0] FCS_POLY   = 16'h8408;
	localparam logic [15:0] FCS_GOOD   = 16'hF0B8;
	// ==================================================================
	// Transmit end register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CTLOCT = 8'h08;
	localparam logic [7:0] REG_SRC    = 8'h0C;
	localparam logic [7:0] REG_PFX_LO = 8'h10;
	localparam logic [7:0] REG_PFX_HI = 8'h14;
	localparam logic [7:0] REG_DEST0  = 8'h18;
	localparam logic [7:0] REG_INFO0  = 8'h28;
	localparam logic [7:0] REG_END    = 8'h38;
	localparam int CTRL_START    = 0;
	localparam int CTRL_OP_LO    = 1;
	localparam int CTRL_MODE_LO  = 3;
	localparam int CTRL_CR       = 5;
	localparam int CTRL_V6       = 6;
	localparam int CTRL_NDEST_LO = 8;
	localparam int CTRL_ILEN_LO  = 12;
	// ==================================================================
	// Modes and frame kinds
	typedef enum logic [1:0] {OP_CONNLESS, OP_CONN, OP_ACK_CONNLESS, OP_DECOUPLED} op_type_t;
	typedef enum logic [1:0] {KIND_INFO, KIND_SUP, KIND_UNN} kind_t;
	typedef enum logic [1:0] {AM_ONE, AM_FOUR, AM_SIX, AM_RSVD} addr_mode_t;

	function automatic logic kind_allowed(input op_type_t op, input kind_t k);
		if (k == KIND_UNN)
			return 1'b1;
		if (k == KIND_INFO)
			return op == OP_CONN;
		return (op == OP_CONN) || (op == OP_DECOUPLED);
	endfunction

	function automatic kind_t kind_of_ctrl(input logic [7:0] c);
		if (!c[0])
			return KIND_INFO;
		if (!c[1])
			return KIND_SUP;
		return KIND_UNN;
	endfunction

	function automatic logic [2:0] addr_len(input addr_mode_t m);
		return (m == AM_SIX) ? LEN_SIX : LEN_FOUR;
	endfunction

	function automatic logic [6:0] marker(input addr_mode_t m);
		return (m == AM_SIX) ? MARK_SIX : MARK_FOUR;
	endfunction
endpackage

// ===== link_if.sv
// Serial bit link joining the transmit end and the receive end
`timescale 1ns/10ps
interface link_if;
	logic line_bit;	// Serial data bit
	logic line_en;	// Bit valid this cycle

	modport tx_end (output line_bit, output line_en);
	modport rx_end (input line_bit, input line_en);
endinterface

// ===== fcs16_step.sv
// One-octet update of the 16-bit frame check sequence, LSB first
`timescale 1ns/10ps
module fcs16_step (
	input  wire logic [15:0] crc_in,	// Running check value
	input  wire logic [7:0]  octet,		// Octet to absorb
	output logic      [15:0] crc_out	// Updated check value
);
	import frame_codec_pkg::*;

	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ octet[i]) begin
				c = (c >> 1) ^ FCS_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crc_out = c;
	end
endmodule

// ===== link_frame_rx.sv
// Station receive end: flag sync, destuffing, address parse, frame checks
// ======================================================================
`timescale 1ns/10ps
module link_frame_rx (
	input  wire logic                          pclk,		// Clock, 100 MHz
	input  wire logic                          presetn,	// Async reset
	link_if.rx_end                             link,		// Serial link
	input  wire logic                          cfg_ip_v6,	// Network layer is v6
	input  wire frame_codec_pkg::addr_mode_t   cfg_mode,	// Net address size
	input  wire frame_codec_pkg::op_type_t     cfg_op,		// Operation type
	output logic                               frame_ok,	// Good frame pulse
	output logic                               frame_bad,	// Discard pulse
	output frame_codec_pkg::kind_t             frame_kind,	// Kind of good frame
	output logic [4:0]                         dest_count,	// Destination entries
	output logic [47:0]                        src_addr,	// Source address
	output logic                               src_cr,		// Command/response
	output logic [7:0]                         info_data,	// Information octet
	output logic                               info_valid	// Info octet pulse
);
	import frame_codec_pkg::*;

	typedef enum logic {RX_HUNT, RX_FRAME} rx_st_t;
	typedef enum logic [1:0] {PH_DEST, PH_SRC, PH_CTRL, PH_BODY} rx_ph_t;

	typedef struct packed {
		rx_st_t      st;
		rx_ph_t      ph;
		logic [2:0]  ones;
		logic [2:0]  bcnt;
		logic [7:0]  sh;
		logic [2:0]  sub;
		logic        ext;
		logic [4:0]  ndest;
		logic [1:0]  nbody;
		logic [7:0]  h0;
		logic [7:0]  h1;
		logic [15:0] crc;
		kind_t       kind;
		logic [47:0] src;
		logic        cr;
		logic        ok;
		logic        bad;
		kind_t       kind_o;
		logic [4:0]  ndest_o;
		logic [47:0] src_o;
		logic        cr_o;
		logic [7:0]  info_d;
		logic        info_v;
	} rx_state_t;

	rx_state_t   s_r;
	rx_state_t   s_nxt;
	logic [7:0]  oct_w;
	logic [15:0] crc_w;
	addr_mode_t  mode_w;
	logic        multi_w;
	logic [2:0]  alen_w;
	logic [6:0]  mark_w;

	// ==================================================================
	// Address size of this station
	assign mode_w  = cfg_ip_v6 ? AM_SIX : cfg_mode;
	assign multi_w = (mode_w == AM_FOUR) || (mode_w == AM_SIX);
	assign alen_w  = addr_len(mode_w);
	assign mark_w  = marker(mode_w);
	assign oct_w   = {link.line_bit, s_r.sh[7:1]};

	fcs16_step u_fcs (
		.crc_in  (s_r.crc),
		.octet   (oct_w),
		.crc_out (crc_w)
	);

	// ==================================================================
	// Bit and octet processing
	always_comb begin
		logic push;
		logic flag;
		logic has_data;
		logic good;
		push     = 1'b0;
		flag     = 1'b0;
		has_data = (s_r.ph != PH_DEST) || (s_r.ndest != 5'h00);
		good     = (s_r.ph == PH_BODY) && (s_r.nbody == 2'h2) && (s_r.bcnt == 3'h6)
			&& (s_r.crc == FCS_GOOD) && kind_allowed(cfg_op, s_r.kind);
		s_nxt        = s_r;
		s_nxt.ok     = 1'b0;
		s_nxt.bad    = 1'b0;
		s_nxt.info_v = 1'b0;
		if (link.line_en) begin
			if (link.line_bit) begin
				if (s_r.ones >= FLAG_RUN) begin
					// Seven ones: abort, hunt for the next flag
					s_nxt.ones = 3'h7;
					s_nxt.st   = RX_HUNT;
					s_nxt.bad  = (s_r.st == RX_FRAME) && has_data;
				end else begin
					s_nxt.ones = s_r.ones + 3'h1;
					push       = (s_r.ones != STUFF_RUN);
				end
			end else begin
				s_nxt.ones = 3'h0;
				flag       = (s_r.ones == FLAG_RUN);
				push       = (s_r.ones != FLAG_RUN) && (s_r.ones != STUFF_RUN);
			end
		end
		if (flag) begin
			// Closing flag ends a frame and opens the next
			if (s_r.st == RX_FRAME && good) begin
				s_nxt.ok      = 1'b1;
				s_nxt.kind_o  = s_r.kind;
				s_nxt.ndest_o = s_r.ndest;
				s_nxt.src_o   = s_r.src;
				s_nxt.cr_o    = s_r.cr;
			end else if (s_r.st == RX_FRAME && has_data) begin
				s_nxt.bad = 1'b1;
			end
			s_nxt.st    = RX_FRAME;
			s_nxt.ph    = PH_DEST;
			s_nxt.bcnt  = 3'h0;
			s_nxt.sub   = 3'h0;
			s_nxt.ext   = 1'b0;
			s_nxt.ndest = 5'h00;
			s_nxt.nbody = 2'h0;
			s_nxt.crc   = FCS_INIT;
		end else if (push && s_r.st == RX_FRAME) begin
			s_nxt.sh   = oct_w;
			s_nxt.bcnt = s_r.bcnt + 3'h1;
			if (s_r.bcnt == 3'h7) begin
				s_nxt.crc = crc_w;
				unique case (s_r.ph)
					PH_DEST: begin
						if (s_r.sub != 3'h0) begin
							// Octets of a long address
							s_nxt.sub = s_r.sub - 3'h1;
							if (s_r.sub == 3'h1 && s_r.ext) begin
								s_nxt.ph = PH_SRC;
							end
						end else if (s_r.ndest == MAX_DEST) begin
							s_nxt.st  = RX_HUNT;
							s_nxt.bad = 1'b1;
						end else begin
							s_nxt.ndest = s_r.ndest + 5'h01;
							if (multi_w && oct_w[7:1] == mark_w) begin
								s_nxt.sub = alen_w;
								s_nxt.ext = oct_w[0];
							end else if (oct_w[0]) begin
								s_nxt.ph = PH_SRC;
							end
						end
					end
					PH_SRC: begin
						if (s_r.sub != 3'h0) begin
							s_nxt.src = {s_r.src[39:0], oct_w};
							s_nxt.sub = s_r.sub - 3'h1;
							if (s_r.sub == 3'h1) begin
								s_nxt.ph = PH_CTRL;
							end
						end else if (multi_w && oct_w[7:1] == mark_w) begin
							s_nxt.cr  = oct_w[0];
							s_nxt.sub = alen_w;
							s_nxt.src = 48'h0;
						end else begin
							s_nxt.src = {41'h0, oct_w[7:1]};
							s_nxt.cr  = oct_w[0];
							s_nxt.ph  = PH_CTRL;
						end
					end
					PH_CTRL: begin
						s_nxt.kind = kind_of_ctrl(oct_w);
						s_nxt.ph   = PH_BODY;
					end
					PH_BODY: begin
						// Two-octet lag keeps the FCS off the info output
						s_nxt.h0 = oct_w;
						s_nxt.h1 = s_r.h0;
						if (s_r.nbody == 2'h2) begin
							s_nxt.info_d = s_r.h1;
							s_nxt.info_v = 1'b1;
						end else begin
							s_nxt.nbody = s_r.nbody + 2'h1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==================================================================
	// Registered outputs
	assign frame_ok   = s_r.ok;
	assign frame_bad  = s_r.bad;
	assign frame_kind = s_r.kind_o;
	assign dest_count = s_r.ndest_o;
	assign src_addr   = s_r.src_o;
	assign src_cr     = s_r.cr_o;
	assign info_data  = s_r.info_d;
	assign info_valid = s_r.info_v;
endmodule

// ===== link_frame_tx.sv
// Peer transmit end: APB-programmed frame builder with bit stuffing
`timescale 1ns/10ps
module link_frame_tx (
	input  wire logic        pclk,		// Clock, 100 MHz
	input  wire logic        presetn,	// Async reset
	input  wire logic [7:0]  paddr,		// APB address
	input  wire logic        psel,		// APB select
	input  wire logic        penable,	// APB enable
	input  wire logic        pwrite,	// APB write
	input  wire logic [31:0] pwdata,	// APB write data
	output logic      [31:0] prdata,	// APB read data
	output logic             pready,	// APB ready
	output logic             pslverr,	// APB error
	link_if.tx_end           link		// Serial link
);
	import frame_codec_pkg::*;

	typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DEST, TX_SRC, TX_CTRL, TX_INFO, TX_FCS,
		TX_CLOSE} tx_st_t;
	typedef enum logic [3:0] {SEL_CTRL, SEL_STATUS, SEL_CTLOCT, SEL_SRC, SEL_PFX_LO, SEL_PFX_HI,
		SEL_DEST, SEL_INFO, SEL_NONE} reg_sel_t;

	typedef struct packed {
		tx_st_t       st;
		logic [7:0]   oct;
		logic [2:0]   bcnt;
		logic [2:0]   ones;
		logic [3:0]   ent;
		logic [2:0]   sub;
		logic [3:0]   icnt;
		logic         fsel;
		logic [15:0]  crc;
		logic         busy;
		logic         refused;
		op_type_t     op;
		addr_mode_t   mode;
		logic         cr;
		logic         v6;
		logic [3:0]   ndest;
		logic [4:0]   ilen;
		logic [7:0]   ctloct;
		logic [7:0]   src;
		logic [39:0]  pfx;
		logic [127:0] dest;
		logic [127:0] info;
		logic         pready;
		logic [31:0]  prdata;
		logic         pslverr;
		logic         lbit;
		logic         len;
	} tx_state_t;

	tx_state_t   s_r;
	tx_state_t   s_nxt;
	logic [15:0] crc_w;

	function automatic reg_sel_t reg_sel(input logic [7:0] a);
		if (a[1:0] != 2'h0)
			return SEL_NONE;
		if (a >= REG_DEST0 && a < REG_INFO0)
			return SEL_DEST;
		if (a >= REG_INFO0 && a < REG_END)
			return SEL_INFO;
		case (a)
			REG_CTRL:   return SEL_CTRL;
			REG_STATUS: return SEL_STATUS;
			REG_CTLOCT: return SEL_CTLOCT;
			REG_SRC:    return SEL_SRC;
			REG_PFX_LO: return SEL_PFX_LO;
			REG_PFX_HI: return SEL_PFX_HI;
			default:    return SEL_NONE;
		endcase
	endfunction

	// Octet of an address entry; bit 7 of the entry marks a single-octet special
	function automatic logic [7:0] addr_oct(input logic [7:0] eb, input logic [2:0] sub,
		input logic lsb, input logic multi, input logic [2:0] alen, input logic [6:0] mk,
		input logic [39:0] pfx);
		logic [2:0] k;
		k = alen - sub - 3'h1;
		if (!multi || eb[7])
			return {eb[6:0], lsb};
		if (sub == 3'h0)
			return {mk, lsb};
		if (sub == alen)
			return {1'b0, eb[6:0]};
		return pfx[{k, 3'h0} +: 8];
	endfunction

	fcs16_step u_fcs (
		.crc_in  (s_r.crc),
		.octet   (s_r.oct),
		.crc_out (crc_w)
	);

	always_comb begin
		reg_sel_t   sel;
		logic [7:0] woff;
		logic [1:0] wi;
		addr_mode_t em;
		logic       multi;
		logic [2:0] alen;
		logic [6:0] mk;
		logic [7:0] eb;
		logic       done;
		logic [3:0] e1;
		op_type_t   wop;
		addr_mode_t wmode;
		logic [3:0] ni;
		sel   = reg_sel(paddr);
		woff  = paddr - ((sel == SEL_DEST) ? REG_DEST0 : REG_INFO0);
		wi    = woff[3:2];
		em    = s_r.v6 ? AM_SIX : s_r.mode;
		multi = (em == AM_FOUR) || (em == AM_SIX);
		alen  = addr_len(em);
		mk    = marker(em);
		eb    = (s_r.st == TX_SRC) ? s_r.src : s_r.dest[{s_r.ent, 3'h0} +: 8];
		done  = !multi || eb[7] || (s_r.sub == alen);
		e1    = s_r.ent + 4'h1;
		wop   = op_type_t'(pwdata[CTRL_OP_LO +: 2]);
		wmode = addr_mode_t'(pwdata[CTRL_MODE_LO +: 2]);
		ni    = (s_r.st == TX_CTRL) ? 4'h0 : s_r.icnt + 4'h1;
		s_nxt = s_r;
		// ==============================================================
		// APB slave: ready one cycle into the access phase
		s_nxt.pready = psel && penable && !s_r.pready;
		if (psel && penable && !s_r.pready) begin
			s_nxt.pslverr = (sel == SEL_NONE);
			unique case (sel)
				SEL_CTRL:   s_nxt.prdata = {15'h0, s_r.ilen, s_r.ndest, 1'b0, s_r.v6, s_r.cr,
					s_r.mode, s_r.op, 1'b0};
				SEL_STATUS: s_nxt.prdata = {30'h0, s_r.refused, s_r.busy};
				SEL_CTLOCT: s_nxt.prdata = {24'h0, s_r.ctloct};
				SEL_SRC:    s_nxt.prdata = {24'h0, s_r.src};
				SEL_PFX_LO: s_nxt.prdata = s_r.pfx[31:0];
				SEL_PFX_HI: s_nxt.prdata = {24'h0, s_r.pfx[39:32]};
				SEL_DEST:   s_nxt.prdata = s_r.dest[{wi, 5'h0} +: 32];
				SEL_INFO:   s_nxt.prdata = s_r.info[{wi, 5'h0} +: 32];
				SEL_NONE:   s_nxt.prdata = 32'h0;
			endcase
		end
		// Writes land at the edge that completes the access; ignored while busy
		if (psel && penable && s_r.pready && pwrite && !s_r.busy) begin
			unique case (sel)
				SEL_CTRL: begin
					s_nxt.op    = wop;
					s_nxt.mode  = wmode;
					s_nxt.cr    = pwdata[CTRL_CR];
					s_nxt.v6    = pwdata[CTRL_V6];
					s_nxt.ndest = pwdata[CTRL_NDEST_LO +: 4];
					s_nxt.ilen  = pwdata[CTRL_ILEN_LO +: 5];
					if (pwdata[CTRL_START]) begin
						if (kind_allowed(wop, kind_of_ctrl(s_r.ctloct)) && wmode != AM_RSVD
							&& pwdata[CTRL_ILEN_LO +: 5] <= MAX_INFO) begin
							s_nxt.busy    = 1'b1;
							s_nxt.refused = 1'b0;
							s_nxt.st      = TX_OPEN;
							s_nxt.oct     = FLAG_OCTET;
							s_nxt.bcnt    = 3'h0;
							s_nxt.ones    = 3'h0;
							s_nxt.crc     = FCS_INIT;
						end else begin
							s_nxt.refused = 1'b1;
						end
					end
				end
				SEL_CTLOCT: s_nxt.ctloct = pwdata[7:0];
				SEL_SRC:    s_nxt.src = pwdata[7:0];
				SEL_PFX_LO: s_nxt.pfx[31:0] = pwdata;
				SEL_PFX_HI: s_nxt.pfx[39:32] = pwdata[7:0];
				SEL_DEST:   s_nxt.dest[{wi, 5'h0} +: 32] = pwdata;
				SEL_INFO:   s_nxt.info[{wi, 5'h0} +: 32] = pwdata;
				SEL_STATUS, SEL_NONE: ;
			endcase
		end
		// ==============================================================
		// Bit serialiser and field sequencer
		s_nxt.len = s_r.busy;
		if (s_r.busy) begin
			if (s_r.ones == STUFF_RUN) begin
				s_nxt.lbit = 1'b0;
				s_nxt.ones = 3'h0;
			end else begin
				s_nxt.lbit = s_r.oct[s_r.bcnt];
				s_nxt.ones = (s_r.st == TX_OPEN || s_r.st == TX_CLOSE || !s_r.oct[s_r.bcnt]) ?
					3'h0 : s_r.ones + 3'h1;
				s_nxt.bcnt = s_r.bcnt + 3'h1;
				if (s_r.bcnt == 3'h7) begin
					if (s_r.st inside {TX_DEST, TX_SRC, TX_CTRL, TX_INFO}) begin
						s_nxt.crc = crc_w;
					end
					unique case (s_r.st)
						TX_OPEN: begin
							s_nxt.st  = TX_DEST;
							s_nxt.ent = 4'h0;
							s_nxt.sub = 3'h0;
							s_nxt.oct = addr_oct(s_r.dest[7:0], 3'h0, s_r.ndest == 4'h0, multi,
								alen, mk, s_r.pfx);
						end
						TX_DEST: begin
							if (!done) begin
								s_nxt.sub = s_r.sub + 3'h1;
								s_nxt.oct = addr_oct(eb, s_r.sub + 3'h1, 1'b0, multi, alen, mk,
									s_r.pfx);
							end else if (s_r.ent == s_r.ndest) begin
								s_nxt.st  = TX_SRC;
								s_nxt.sub = 3'h0;
								s_nxt.oct = addr_oct(s_r.src, 3'h0, s_r.cr, multi, alen, mk, s_r.pfx);
							end else begin
								s_nxt.ent = e1;
								s_nxt.sub = 3'h0;
								s_nxt.oct = addr_oct(s_r.dest[{e1, 3'h0} +: 8], 3'h0,
									e1 == s_r.ndest, multi, alen, mk, s_r.pfx);
							end
						end
						TX_SRC: begin
							if (!done) begin
								s_nxt.sub = s_r.sub + 3'h1;
								s_nxt.oct = addr_oct(eb, s_r.sub + 3'h1, 1'b0, multi, alen, mk,
									s_r.pfx);
							end else begin
								s_nxt.st  = TX_CTRL;
								s_nxt.oct = s_r.ctloct;
							end
						end
						TX_CTRL, TX_INFO: begin
							if ((s_r.st == TX_CTRL && s_r.ilen == 5'h00)
								|| (s_r.st == TX_INFO && {1'b0, s_r.icnt} + 5'h01 == s_r.ilen)) begin
								s_nxt.st   = TX_FCS;
								s_nxt.fsel = 1'b0;
								s_nxt.oct  = ~crc_w[7:0];
							end else begin
								s_nxt.icnt = ni;
								s_nxt.st   = TX_INFO;
								s_nxt.oct  = s_r.info[{ni, 3'h0} +: 8];
							end
						end
						TX_FCS: begin
							s_nxt.fsel = 1'b1;
							s_nxt.oct  = s_r.fsel ? FLAG_OCTET : ~s_r.crc[15:8];
							s_nxt.st   = s_r.fsel ? TX_CLOSE : TX_FCS;
						end
						TX_CLOSE: begin
							s_nxt.st   = TX_IDLE;
							s_nxt.busy = 1'b0;
						end
						TX_IDLE: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata        = s_r.prdata;
	assign pready        = s_r.pready;
	assign pslverr       = s_r.pslverr;
	assign link.line_bit = s_r.lbit;
	assign link.line_en  = s_r.len;
endmodule

// ===== link_frame_chk.sv
// Link checker: flag framing, zero insertion and frame length on the wire
`timescale 1ns/10ps
module link_frame_chk
	import frame_codec_pkg::*;
(
	input wire logic pclk,		// Clock
	input wire logic presetn,	// Async reset
	input wire logic line_bit,	// Serial data bit
	input wire logic line_en	// Bit valid
);
	// ====================
	// Run and length trackers
	logic [2:0]  ones_r;
	logic [11:0] nd_r;
	logic [7:0]  last_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ones_r <= 3'h0;
			nd_r   <= 12'h000;
			last_r <= 8'h00;
		end else if (line_en) begin
			ones_r <= line_bit ? ones_r + 3'h1 : 3'h0;
			last_r <= {line_bit, last_r[7:1]};
			if (!(ones_r == STUFF_RUN && !line_bit))
				nd_r <= nd_r + 12'h001;
		end else begin
			ones_r <= 3'h0;
			nd_r   <= 12'h000;
		end
	end

	// ====================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_open_flag: assert property ($rose(line_en) |->
		!line_bit ##1 (line_en && line_bit) [*6] ##1 (line_en && !line_bit))
		else $error("opening flag malformed");
	chk_close_flag: assert property ($fell(line_en) |-> last_r == FLAG_OCTET)
		else $error("closing flag malformed");
	chk_close_run: assert property ($fell(line_en) |->
		$past(ones_r) == FLAG_RUN && !$past(line_bit))
		else $error("frame end not after six ones");
	chk_no_abort: assert property (ones_r <= FLAG_RUN)
		else $error("seven ones on the line");
	chk_stuff_close: assert property (line_en && line_bit && ones_r == STUFF_RUN
		&& nd_r > 12'h008 |=> (line_en && !line_bit) ##1 !line_en)
		else $error("six ones inside a frame");
	chk_octet_align: assert property ($fell(line_en) |-> nd_r[2:0] == 3'h0)
		else $error("frame not whole octets");
	chk_min_length: assert property ($fell(line_en) |-> nd_r >= 12'h038)
		else $error("frame too short");
	chk_max_length: assert property (line_en |-> nd_r <= 12'h460)
		else $error("frame too long");

	cover property ($rose(line_en));
	cover property (line_en && !line_bit && ones_r == STUFF_RUN);
	cover property ($fell(line_en) && nd_r > 12'h200);
endmodule

// ===== tb.sv
// Testbench: APB-programmed transmit end looped into the receive end
`timescale 1ns/10ps
module tb;
	import frame_codec_pkg::*;
	typedef struct {
		op_type_t op; addr_mode_t md; logic v6; logic [7:0] ctl;
		logic [4:0] nd, il; logic [7:0] src; logic cr, rf; kind_t kd;
	} row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, info_data;
	logic [31:0] pwdata, prdata, rd;
	logic        cfg_ip_v6, frame_ok, frame_bad, src_cr, info_valid;
	addr_mode_t  cfg_mode;
	op_type_t    cfg_op;
	kind_t       frame_kind;
	logic [4:0]  dest_count;
	logic [47:0] src_addr;
	int          n_errors, check_count;
	logic [7:0]  iq[$];
	row_t        rows[13];

	link_if i_link_if ();
	link_frame_tx i_link_frame_tx (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .link(i_link_if));
	link_frame_rx i_link_frame_rx (.pclk, .presetn, .link(i_link_if), .cfg_ip_v6,
		.cfg_mode, .cfg_op, .frame_ok, .frame_bad, .frame_kind, .dest_count,
		.src_addr, .src_cr, .info_data, .info_valid);
	link_frame_chk i_link_frame_chk (.pclk, .presetn, .line_bit(i_link_if.line_bit),
		.line_en(i_link_if.line_en));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk)
		if (info_valid === 1'b1)
			iq.push_back(info_data);

	// ====================
	// Helpers
	function automatic logic [7:0] ib(input int k);
		return 8'hF8 ^ 8'(k);
	endfunction

	function automatic logic [7:0] db(input int n);
		return (n == 5) ? 8'h85 : 8'h7F ^ 8'(n);
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: %h vs %h", $time, m, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic send(input row_t r, input logic good);
		logic [31:0] c;
		c = 32'h0;
		c[CTRL_START] = 1'b1;
		c[CTRL_OP_LO+:2] = r.op;
		c[CTRL_MODE_LO+:2] = r.md;
		c[CTRL_CR] = r.cr;
		c[CTRL_V6] = r.v6;
		c[CTRL_NDEST_LO+:4] = 4'(r.nd - 5'h01);
		c[CTRL_ILEN_LO+:5] = r.il;
		apb(1'b1, REG_SRC, {24'h0, r.src});
		apb(1'b1, REG_CTLOCT, {24'h0, r.ctl});
		iq.delete();
		apb(1'b1, REG_CTRL, c);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, {30'h0, r.rf, ~r.rf}, "status");
		apb(1'b1, REG_CTLOCT, 32'h0);
		if (!r.rf) begin
			repeat (4000) begin
				@(posedge pclk);
				if (frame_ok === 1'b1 || frame_bad === 1'b1)
					break;
			end
			chk(frame_ok, good, "frame ok");
			chk(frame_bad, !good, "frame bad");
			for (int k = 0; k < 40 && rd[0] !== 1'b0; k++)
				apb(1'b0, REG_STATUS, 32'h0);
			apb(1'b0, REG_CTLOCT, 32'h0);
			chk(rd, {24'h0, r.ctl}, "busy write");
			if (good) begin
				chk(frame_kind, r.kd, "kind");
				chk(dest_count, r.nd, "dests");
				chk(src_cr, r.cr, "cr");
				if (r.md == AM_ONE)
					chk(src_addr, r.src[6:0], "src");
				else if (r.md == AM_FOUR)
					chk(src_addr, {24'hFFFFFF, 1'b0, r.src[6:0]}, "src four");
				else
					chk(src_addr, {40'hFFFFFFFFFF, 1'b0, r.src[6:0]}, "src six");
				chk(64'(iq.size()), r.il, "info count");
				foreach (iq[k])
					chk(iq[k], ib(k), "info");
			end
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge pclk);
		n_errors++;
		end_of_test();
	end

	// ====================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cfg_ip_v6} = '0;
		cfg_mode = AM_ONE;
		cfg_op = OP_CONNLESS;
		rows = '{
			'{OP_CONNLESS, AM_ONE, 1'b0, 8'h03, 5'h01, 5'h00, 8'h7F, 1'b1, 1'b0, KIND_UNN},
			'{OP_CONN, AM_ONE, 1'b0, 8'h00, 5'h10, 5'h10, 8'h15, 1'b0, 1'b0, KIND_INFO},
			'{OP_ACK_CONNLESS, AM_ONE, 1'b0, 8'h03, 5'h02, 5'h01, 8'h3E, 1'b1, 1'b0, KIND_UNN},
			'{OP_DECOUPLED, AM_ONE, 1'b0, 8'h01, 5'h03, 5'h04, 8'h01, 1'b0, 1'b0, KIND_SUP},
			'{OP_CONN, AM_FOUR, 1'b0, 8'h01, 5'h07, 5'h02, 8'h6A, 1'b1, 1'b0, KIND_SUP},
			'{OP_CONN, AM_SIX, 1'b1, 8'h00, 5'h10, 5'h03, 8'h7F, 1'b0, 1'b0, KIND_INFO},
			'{OP_CONNLESS, AM_ONE, 1'b0, 8'h00, 5'h01, 5'h01, 8'h10, 1'b0, 1'b1, KIND_INFO},
			'{OP_CONNLESS, AM_ONE, 1'b0, 8'h01, 5'h01, 5'h00, 8'h10, 1'b0, 1'b1, KIND_SUP},
			'{OP_ACK_CONNLESS, AM_ONE, 1'b0, 8'h00, 5'h01, 5'h00, 8'h10, 1'b0, 1'b1, KIND_INFO},
			'{OP_ACK_CONNLESS, AM_ONE, 1'b0, 8'h01, 5'h01, 5'h00, 8'h10, 1'b0, 1'b1, KIND_SUP},
			'{OP_DECOUPLED, AM_ONE, 1'b0, 8'h00, 5'h01, 5'h00, 8'h10, 1'b0, 1'b1, KIND_INFO},
			'{OP_CONN, AM_RSVD, 1'b0, 8'h03, 5'h01, 5'h00, 8'h10, 1'b0, 1'b1, KIND_UNN},
			'{OP_CONN, AM_FOUR, 1'b0, 8'h00, 5'h01, 5'h11, 8'h10, 1'b0, 1'b1, KIND_INFO}};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, REG_PFX_LO, 32'hFFFFFFFF);
		apb(1'b1, REG_PFX_HI, 32'h000000FF);
		for (int w = 0; w < 4; w++) begin
			apb(1'b1, REG_DEST0 + 8'(4 * w), {db(4*w+3), db(4*w+2), db(4*w+1), db(4*w)});
			apb(1'b1, REG_INFO0 + 8'(4 * w), {ib(4*w+3), ib(4*w+2), ib(4*w+1), ib(4*w)});
		end
		foreach (rows[i]) begin
			cfg_mode <= rows[i].md;
			cfg_op <= rows[i].op;
			cfg_ip_v6 <= rows[i].v6;
			send(rows[i], 1'b1);
		end
		// Receiver set to another operation type than the sender
		cfg_mode <= AM_ONE;
		cfg_ip_v6 <= 1'b0;
		cfg_op <= OP_CONNLESS;
		send(rows[1], 1'b0);
		cfg_op <= OP_ACK_CONNLESS;
		send(rows[3], 1'b0);
		apb(1'b0, REG_END, 32'h0);
		chk({err, rd}, 33'h100000000, "unmapped");
		apb(1'b1, 8'h02, 32'h0);
		chk(err, 1'b1, "unaligned");
		// Reset in mid-frame
		apb(1'b1, REG_CTRL, 32'h00000003);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk({i_link_if.line_en, pready, frame_kind, dest_count, src_addr, src_cr}, 0,
			"reset outputs");
		// Second edge in reset keeps the line checks off across the drop
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h0, "status reset");
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0, "ctrl reset");
		end_of_test();
	end
endmodule
